// *** hw/ext_bus_if.sv ***
/*
 * External bus interface and address decoder of a 16-bit microcontroller.
 * Assumes a core-side request port on i_clk; wait, hold, width and mode pins are synchronised here.
 */
// Function
// R1: Width select low gives 16-bit external data bus, high gives 8-bit.
// R2: Board holds width select constant and low in single-chip mode.
// R3: Mode strap low selects single-chip, high selects microprocessor mode after reset.
// R4: Separate bus uses low data byte; upper byte only for 16-bit width.
// R5: Drive 20-bit address on dedicated outputs zero to nineteen.
// R6: 8-bit multiplexed bus puts address bits 0-7 on low data lines first.
// R7: 16-bit multiplexed bus puts address bits 1-8 on low data lines first.
// R8: Assert one of four active-low chip selects for the target area.
// R9: Split strobes: even write, odd write, read strobes on 16-bit bus.
// R10: Combined strobes: one write, upper byte enable, read; forced on 8-bit bus.
// R11: Output address latch strobe for external address capture.
// R12: Hold request unsupported; board pulls hold request input high. The code enters hold on a low hold request while i_hold_enter is set.
// R13: Hold acknowledge driven low while bus is in hold.
// R14: Low wait request extends bus cycle; resume once it returns high.
// R15: Decode 1 MB space, 4 MB with area expansion.
// R16: 40000h-BFFFFh route to external banks zero to seven.
// R17: Special register windows 00000h-003FFh and 0D000h-0D7FFh; gaps not accessed.
// R18: Internal RAM 00400h-02BFFh for data and stack.
// R19: Data flash at 0E000h-0FFFFh.
// R20: Secondary program flash at 10000h-13FFFh.
// R21: Primary program flash 64 KB at F0000h-FFFFFh.
// R22: Fixed vector table FFFDCh-FFFFFh inside primary flash.
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_regs.svh"
module ext_bus_if (
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_nrst,
	// Straps and configuration
	input  wire logic                    i_bus_width_8,
	input  wire logic                    i_processor_mode_strap,
	input  wire logic                    i_multiplexed,
	input  wire logic                    i_combined_strobes,
	input  wire logic                    i_area_expand,
	input  wire logic                    i_hold_enter,
	// Core request
	input  wire logic                    i_req,
	input  wire logic                    i_we,
	input  wire logic [`XADDR_W-1:0]     i_addr,
	input  wire logic [`DATA_W-1:0]      i_wdata,
	output logic                         o_ack,
	output logic [`DATA_W-1:0]           o_rdata,
	output ext_bus_pkg::region_t         o_region,
	output logic                         o_vector,
	output logic                         o_single_chip,
	// External bus pins
	output logic [`ADDR_W-1:0]           o_addr,
	input  wire logic [`DATA_W-1:0]      i_data,
	output logic [`DATA_W-1:0]           o_data,
	output logic [1:0]                   o_data_oe,
	output logic [`CS_NUM-1:0]           o_chip_select_n,
	output logic                         o_write_strobe_even_n,
	output logic                         o_write_strobe_odd_n,
	output logic                         o_read_strobe_n,
	output logic                         o_addr_latch,
	input  wire logic                    i_wait_request_n,
	input  wire logic                    i_hold_request_n,
	output logic                         o_hold_acknowledge_n
);
	import ext_bus_pkg::*;

	localparam logic [1:0] ADDR_CNT = 2'(`ADDR_PH_CYC);
	localparam logic [1:0] STRB_CNT = 2'(`STROBE_CYC);

	logic       wait_n_s;
	logic       hold_n_s;
	logic       width8_s;
	logic       strap_s;
	region_t    dec_region;
	logic [2:0] dec_bank;
	logic       dec_vec;

	bus_state_t              st_q, st_d;
	logic [1:0]              cnt_q, cnt_d;
	logic                    single_q, single_d;
	logic [1:0]              cfg_q, cfg_d;
	logic [`ADDR_W-1:0]      addr_q, addr_d;
	logic [`DATA_W-1:0]      dout_q, dout_d;
	logic [1:0]              oe_q, oe_d;
	logic [`DATA_W-1:0]      rdata_q, rdata_d;
	logic [`CS_NUM-1:0]      cs_n_q, cs_n_d;
	logic                    wre_n_q, wre_n_d;
	logic                    wro_n_q, wro_n_d;
	logic                    rd_n_q, rd_n_d;
	logic                    ale_q, ale_d;
	logic                    hold_acknowledge_n_n_q, hold_acknowledge_n_n_d;
	logic                    ack_q, ack_d;
	logic                    we_q, we_d;
	logic                    w8, comb, odd;
	logic                    strb_rd_n, strb_wre_n, strb_wro_n;

	// Wait, hold, width and mode pin inputs pass two flip-flops first; the data pins are sampled directly
	sync2 #(.RST_VAL(1'b1)) u_sync_wait (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(i_wait_request_n), .o_q(wait_n_s));
	sync2 #(.RST_VAL(1'b1)) u_sync_hold (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(i_hold_request_n), .o_q(hold_n_s));
	sync2 #(.RST_VAL(1'b0)) u_sync_wid  (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(i_bus_width_8), .o_q(width8_s));
	sync2 #(.RST_VAL(1'b0)) u_sync_mode (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(i_processor_mode_strap), .o_q(strap_s));

	addr_decoder u_dec (
		.i_addr        (i_addr),
		.i_area_expand (i_area_expand),
		.i_single_chip (single_q),
		.o_region      (dec_region),
		.o_bank        (dec_bank),
		.o_vector      (dec_vec)
	);

	// Width and strobe scheme; the board keeps the width select fixed
	assign w8   = width8_s;                   // see R1 see R2
	assign comb = i_combined_strobes || w8;   // see R10
	assign odd  = addr_q[0];

	// Strobe levels of the data phase; the byte enable follows address parity
	assign strb_rd_n  = we_q;
	assign strb_wre_n = !we_q || (!comb && odd);      // see R9
	assign strb_wro_n = comb ? !odd : !(we_q && odd); // see R10

	// Bus cycle sequencer and pin drive
	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		single_d   = single_q;
		cfg_d      = (cfg_q == 2'h3) ? cfg_q : cfg_q + 2'h1;
		addr_d     = addr_q;
		dout_d     = dout_q;
		oe_d       = oe_q;
		rdata_d    = rdata_q;
		cs_n_d     = cs_n_q;
		wre_n_d    = 1'b1;
		wro_n_d    = 1'b1;
		rd_n_d     = 1'b1;
		ale_d      = 1'b0;
		hold_acknowledge_n_n_d   = 1'b1;
		ack_d      = 1'b0;
		we_d       = we_q;
		// Mode strap caught once, after its synchroniser has settled
		if (cfg_q == 2'h2) begin
			single_d = !strap_s; // see R3
		end
		case (st_q)
			ST_IDLE: begin
				cs_n_d = {`CS_NUM{1'b1}};
				oe_d   = 2'b00;
				if (i_hold_enter && !hold_n_s) begin
					st_d     = ST_HOLD; // see R12
					hold_acknowledge_n_n_d = 1'b0;    // Acknowledge stands with the hold state
				end else if (i_req && (cfg_q == 2'h3) && !ack_q) begin
					if (dec_region == RGN_EXT) begin
						st_d           = ST_ADDR;
						cnt_d          = ADDR_CNT;
						we_d           = i_we;
						addr_d         = i_addr[`ADDR_W-1:0]; // see R5
						cs_n_d         = {`CS_NUM{1'b1}};
						cs_n_d[dec_bank[1:0]] = 1'b0; // see R8
						ale_d          = 1'b1; // see R11
						if (i_multiplexed) begin
							oe_d   = 2'b01;
							dout_d = w8 ? {8'h00, i_addr[7:0]} : {8'h00, i_addr[8:1]}; // see R6 see R7
						end else begin
							oe_d   = 2'b00;
							dout_d = i_wdata;
						end
					end else begin
						ack_d = 1'b1; // Internal regions answer at once
					end
				end
			end
			ST_ADDR: begin
				cnt_d = cnt_q - 2'h1;
				if (cnt_q == 2'h1) begin
					st_d  = ST_STRB;
					cnt_d = STRB_CNT;
					dout_d = w8 ? {8'h00, (odd ? i_wdata[15:8] : i_wdata[7:0])} : i_wdata;
					oe_d   = !we_q ? 2'b00 : (w8 ? 2'b01 : 2'b11); // see R4
					rd_n_d  = strb_rd_n; // Strobe opens with the data phase
					wre_n_d = strb_wre_n;
					wro_n_d = strb_wro_n;
				end
			end
			ST_STRB, ST_WAIT: begin
				rd_n_d  = strb_rd_n;
				wre_n_d = strb_wre_n; // see R9
				wro_n_d = strb_wro_n; // see R10
				if (!wait_n_s) begin
					st_d = ST_WAIT; // see R14
				end else if (cnt_q > 2'h1) begin
					st_d  = ST_STRB;
					cnt_d = cnt_q - 2'h1;
				end else begin
					rd_n_d  = 1'b1;
					wre_n_d = 1'b1;
					wro_n_d = 1'b1;
					ack_d   = 1'b1;
					st_d    = ST_IDLE;
					cs_n_d  = {`CS_NUM{1'b1}};
					oe_d    = 2'b00;
					if (!we_q) begin
						rdata_d = w8 ? {8'h00, i_data[7:0]} : i_data;
					end
				end
			end
			ST_HOLD: begin
				hold_acknowledge_n_n_d = 1'b0; // see R13
				oe_d     = 2'b00;
				if (hold_n_s || !i_hold_enter) begin
					st_d     = ST_IDLE;
					hold_acknowledge_n_n_d = 1'b1;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q       <= ST_IDLE;
			cnt_q      <= 2'h0;
			single_q   <= 1'b1;
			cfg_q      <= 2'h0;
			addr_q     <= '0;
			dout_q     <= '0;
			oe_q       <= 2'b00;
			rdata_q    <= '0;
			cs_n_q     <= {`CS_NUM{1'b1}};
			wre_n_q    <= 1'b1;
			wro_n_q    <= 1'b1;
			rd_n_q     <= 1'b1;
			ale_q      <= 1'b0;
			hold_acknowledge_n_n_q   <= 1'b1;
			ack_q      <= 1'b0;
			we_q       <= 1'b0;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			single_q   <= single_d;
			cfg_q      <= cfg_d;
			addr_q     <= addr_d;
			dout_q     <= dout_d;
			oe_q       <= oe_d;
			rdata_q    <= rdata_d;
			cs_n_q     <= cs_n_d;
			wre_n_q    <= wre_n_d;
			wro_n_q    <= wro_n_d;
			rd_n_q     <= rd_n_d;
			ale_q      <= ale_d;
			hold_acknowledge_n_n_q   <= hold_acknowledge_n_n_d;
			ack_q      <= ack_d;
			we_q       <= we_d;
		end
	end

	// Outputs
	assign o_ack                 = ack_q;
	assign o_rdata               = rdata_q;
	assign o_region              = dec_region;
	assign o_vector              = dec_vec;
	assign o_single_chip         = single_q;
	assign o_addr                = addr_q;
	assign o_data                = dout_q;
	assign o_data_oe             = oe_q;
	assign o_chip_select_n       = cs_n_q;
	assign o_write_strobe_even_n = wre_n_q;
	assign o_write_strobe_odd_n  = wro_n_q;
	assign o_read_strobe_n       = rd_n_q;
	assign o_addr_latch          = ale_q;
	assign o_hold_acknowledge_n  = hold_acknowledge_n_n_q;

	// Assertions
	property p_width_upper;
		@(posedge i_clk) disable iff (!i_nrst) w8 |-> !o_data_oe[1];
	endproperty
	a_width_upper: assert property (p_width_upper) else $error("upper byte driven on 8-bit bus"); // see R4

	property p_one_cs;
		@(posedge i_clk) disable iff (!i_nrst) $onehot0(~o_chip_select_n);
	endproperty
	a_one_cs: assert property (p_one_cs) else $error("more than one chip select"); // see R8

	property p_ale_then_strobe;
		@(posedge i_clk) disable iff (!i_nrst) $rose(o_addr_latch) |=>
			(!o_addr_latch && st_q == ST_STRB && !(o_read_strobe_n && o_write_strobe_even_n && o_write_strobe_odd_n));
	endproperty
	a_ale_then_strobe: assert property (p_ale_then_strobe) else $error("strobe not after address phase"); // see R11

	property p_wait_hold;
		@(posedge i_clk) disable iff (!i_nrst) (st_q == ST_WAIT && !wait_n_s) |=> !o_ack;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("cycle ended while waiting"); // see R14

	property p_hold_acknowledge_n;
		@(posedge i_clk) disable iff (!i_nrst) (st_q == ST_HOLD) |-> !o_hold_acknowledge_n;
	endproperty
	a_hold_acknowledge_n: assert property (p_hold_acknowledge_n) else $error("hold without acknowledge"); // see R13

	property p_comb_8;
		@(posedge i_clk) disable iff (!i_nrst)
			(comb && !(o_read_strobe_n && o_write_strobe_even_n)) |-> (o_write_strobe_odd_n == !o_addr[0]);
	endproperty
	a_comb_8: assert property (p_comb_8) else $error("byte enable not following address parity"); // see R10

	property p_split_excl;
		@(posedge i_clk) disable iff (!i_nrst) !comb |-> (o_write_strobe_even_n || o_write_strobe_odd_n);
	endproperty
	a_split_excl: assert property (p_split_excl) else $error("both write strobes low"); // see R9

	property p_ram_map;
		@(posedge i_clk) disable iff (!i_nrst)
			(i_addr == 22'h002bff) |-> (o_region == RGN_RAM);
	endproperty
	a_ram_map: assert property (p_ram_map) else $error("RAM top misdecoded"); // see R18

	property p_vec_map;
		@(posedge i_clk) disable iff (!i_nrst) (i_addr == 22'h0fffdc) |-> o_vector;
	endproperty
	a_vec_map: assert property (p_vec_map) else $error("vector misdecoded"); // see R22

	c_ext_read:  cover property (@(posedge i_clk) disable iff (!i_nrst) !o_read_strobe_n ##[1:20] o_ack);
	c_ext_write: cover property (@(posedge i_clk) disable iff (!i_nrst) !o_write_strobe_even_n ##[1:20] o_ack);
	c_waited:    cover property (@(posedge i_clk) disable iff (!i_nrst) st_q == ST_WAIT ##1 o_ack);
	c_hold:      cover property (@(posedge i_clk) disable iff (!i_nrst) !o_hold_acknowledge_n);
endmodule : ext_bus_if
`default_nettype wire

// *** pkg/ext_bus_regs.svh ***
/*
 * Address map, bus figures and timing counts of the external bus interface.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

`define SPR_LO_BASE    20'h00000
`define SPR_LO_END     20'h003ff
`define SPR_HI_BASE    20'h0d000
`define SPR_HI_END     20'h0d7ff
`define RAM_BASE       20'h00400
`define RAM_END        20'h02bff
`define DFLASH_BASE    20'h0e000
`define DFLASH_END     20'h0ffff
`define PROM2_BASE     20'h10000
`define PROM2_END      20'h13fff
`define PROM1_BASE     20'hf0000
`define PROM1_END      20'hfffff
`define VEC_BASE       20'hfffdc
`define VEC_END        20'hfffff
`define EXT_BASE       20'h40000
`define EXT_END        20'hbffff
`define BANK_LSB       16
`define ADDR_W         20
`define XADDR_W        22
`define DATA_W         16
`define CS_NUM         4
`define ADDR_PH_NS     100
`define ADDR_PH_CYC    ((`ADDR_PH_NS + 99) / 100)
`define STROBE_NS      200
`define STROBE_CYC     ((`STROBE_NS + 99) / 100)

`endif

// *** pkg/ext_bus_pkg.sv ***
/*
 * Types of the external bus interface.
 * Assumes ext_bus_regs.svh for the numbers.
 */
`include "ext_bus_regs.svh"
package ext_bus_pkg;
	typedef enum logic [3:0] {
		RGN_NONE   = 4'h0,
		RGN_SPR    = 4'h1,
		RGN_RAM    = 4'h2,
		RGN_DFLASH = 4'h3,
		RGN_PROM2  = 4'h4,
		RGN_PROM1  = 4'h5,
		RGN_VEC    = 4'h6,
		RGN_EXT    = 4'h7
	} region_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ADDR  = 5'b00010,
		ST_STRB  = 5'b00100,
		ST_WAIT  = 5'b01000,
		ST_HOLD  = 5'b10000
	} bus_state_t;
endpackage : ext_bus_pkg

// *** hw/sync2.sv ***
/*
 * Two flip-flop synchroniser for a level from a pin.
 * Assumes one clock and active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Level
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_q;
	logic meta_d;
	logic out_q;
	logic out_d;

	// Next values
	always_comb begin
		meta_d = i_d;
		out_d  = meta_q;
	end

	// Two stages, only the second is read outside
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= RST_VAL;
			out_q  <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			out_q  <= out_d;
		end
	end

	assign o_q = out_q;
endmodule : sync2
`default_nettype wire

// *** hw/addr_decoder.sv ***
/*
 * Combinational decode of a 22-bit address into internal regions and banks.
 * Assumes the address is stable while the requester holds its request.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_regs.svh"
module addr_decoder (
	// Address in
	input  wire logic [`XADDR_W-1:0] i_addr,
	input  wire logic                i_area_expand,
	input  wire logic                i_single_chip,
	// Decode out
	output ext_bus_pkg::region_t     o_region,
	output logic [2:0]               o_bank,
	output logic                     o_vector
);
	import ext_bus_pkg::*;
	logic [`ADDR_W-1:0] a;
	logic               hi_zero;

	// Upper bits only count when the area is expanded to 4 MB
	assign a       = i_addr[`ADDR_W-1:0];
	assign hi_zero = !i_area_expand || (i_addr[`XADDR_W-1:`ADDR_W] == 2'h0);

	// Region priority: expanded area above 1 MB, then vectors inside program flash 1, then disjoint ranges
	always_comb begin
		o_region = RGN_NONE;
		o_vector = 1'b0;
		o_bank   = 3'h0;
		if (!hi_zero) begin
			o_region = i_single_chip ? RGN_NONE : RGN_EXT; // see R15
			o_bank   = i_addr[`BANK_LSB+2:`BANK_LSB];
		end else if (a >= `VEC_BASE) begin
			o_region = RGN_VEC; // see R22
			o_vector = 1'b1;
		end else if (a >= `PROM1_BASE) begin
			o_region = RGN_PROM1; // see R21
		end else if (a <= `SPR_LO_END || (a >= `SPR_HI_BASE && a <= `SPR_HI_END)) begin
			o_region = RGN_SPR; // see R17
		end else if (a >= `RAM_BASE && a <= `RAM_END) begin
			o_region = RGN_RAM; // see R18
		end else if (a >= `DFLASH_BASE && a <= `DFLASH_END) begin
			o_region = RGN_DFLASH; // see R19
		end else if (a >= `PROM2_BASE && a <= `PROM2_END) begin
			o_region = RGN_PROM2; // see R20
		end else if (a >= `EXT_BASE && a <= `EXT_END && !i_single_chip) begin
			o_region = RGN_EXT; // see R16
			o_bank   = 3'(a[`ADDR_W-1:`BANK_LSB] - 4'h4);
		end
	end
endmodule : addr_decoder
`default_nettype wire

// *** dv/ext_mem_model.sv ***
/*
 * Behavioural external memory of sixteen words on the parallel bus.
 * Assumes registered bus outputs from the interface and a single clock.
 */
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
	// Clock, pacing and strobe scheme
	input  wire logic        i_clk,
	input  wire logic [3:0]  i_slow,
	input  wire logic        i_combined,
	// Bus from the interface
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_data,
	input  wire logic [3:0]  i_chip_select_n,
	input  wire logic        i_write_strobe_even_n,
	input  wire logic        i_write_strobe_odd_n,
	input  wire logic        i_read_strobe_n,
	// Bus back to the interface, and the captured write word for the bench
	output logic [15:0]      o_data,
	output logic             o_wait_request_n,
	output logic [15:0]      o_written
);
	logic [15:0] mem [16];
	logic [15:0] last_q;
	logic [3:0]  wait_q;
	logic        sel;
	logic        wr_act;

	// Fixed contents with distinct bytes per word
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = {4'h6, 4'(i), 4'h9, 4'(i)};
		end
		last_q = 16'h0000;
		wait_q = 4'h0;
		o_written = 16'h0000;
	end

	// Write strobe meaning depends on the strobe scheme
	assign sel    = ~&i_chip_select_n;
	assign wr_act = sel & (~i_write_strobe_even_n | (~i_combined & ~i_write_strobe_odd_n));

	// Released data lines show the inverse of the last driven word
	assign o_data = (sel & ~i_read_strobe_n) ? mem[i_addr[4:1]] : ~last_q;
	// Wait request low from chip select on, early enough to pass the pin synchroniser
	assign o_wait_request_n = ~(sel & (wait_q < i_slow));

	// Wait counter, last read word and captured write word
	always @(posedge i_clk) begin
		if (!sel) begin
			wait_q <= 4'h0;
		end else if (wait_q != 4'hf) begin
			wait_q <= wait_q + 4'h1;
		end
		if (sel && !i_read_strobe_n) begin
			last_q <= o_data;
		end
		if (wr_act) begin
			o_written <= i_data;
		end
	end
endmodule : ext_mem_model
`default_nettype wire

// *** dv/tb.sv ***
/*
 * Self-checking bench of the external bus interface and decoder.
 * Assumes ext_bus_pkg compiled first and the memory model beside the design.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ext_bus_pkg::*;
	logic i_clk, i_nrst, i_bus_width_8, i_processor_mode_strap, i_multiplexed, i_combined_strobes;
	logic i_area_expand, i_hold_enter, i_req, i_we, i_wait_request_n, i_hold_request_n;
	logic o_ack, o_vector, o_single_chip, o_write_strobe_even_n, o_write_strobe_odd_n;
	logic o_read_strobe_n, o_addr_latch, o_hold_acknowledge_n;
	logic [21:0] i_addr;
	logic [15:0] i_wdata, o_rdata, i_data, o_data, written, ale_data;
	logic [19:0] o_addr, ale_addr;
	logic [1:0]  o_data_oe;
	logic [3:0]  o_chip_select_n, cs_seen, slow;
	region_t     o_region;
	logic        even_seen, odd_seen, oe1_seen;
	int          errors, checked, cyc, ticks;

	ext_bus_if u_ext_bus_if (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus_width_8(i_bus_width_8),
		.i_processor_mode_strap(i_processor_mode_strap), .i_multiplexed(i_multiplexed),
		.i_combined_strobes(i_combined_strobes), .i_area_expand(i_area_expand), .i_hold_enter(i_hold_enter),
		.i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack), .o_rdata(o_rdata),
		.o_region(o_region), .o_vector(o_vector), .o_single_chip(o_single_chip), .o_addr(o_addr),
		.i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe), .o_chip_select_n(o_chip_select_n),
		.o_write_strobe_even_n(o_write_strobe_even_n), .o_write_strobe_odd_n(o_write_strobe_odd_n),
		.o_read_strobe_n(o_read_strobe_n), .o_addr_latch(o_addr_latch), .i_wait_request_n(i_wait_request_n),
		.i_hold_request_n(i_hold_request_n), .o_hold_acknowledge_n(o_hold_acknowledge_n));
	ext_mem_model u_ext_mem_model (.i_clk(i_clk), .i_slow(slow), .i_combined(i_combined_strobes | i_bus_width_8),
		.i_addr(o_addr), .i_data(o_data), .i_chip_select_n(o_chip_select_n),
		.i_write_strobe_even_n(o_write_strobe_even_n), .i_write_strobe_odd_n(o_write_strobe_odd_n),
		.i_read_strobe_n(o_read_strobe_n), .o_data(i_data), .o_wait_request_n(i_wait_request_n),
		.o_written(written));

	// Clock of 100 ns period
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// Hang guard
	always @(posedge i_clk) begin
		ticks++;
		if (ticks == 20000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// Reset with given straps; width select only changes here
	task automatic do_reset(input logic strap, input logic w8, input logic mux);
		@(negedge i_clk);
		i_nrst = 1'b0;
		i_processor_mode_strap = strap;
		i_bus_width_8 = w8;
		i_multiplexed = mux;
		repeat (16) @(negedge i_clk);
		cmp({o_chip_select_n, o_read_strobe_n, o_addr_latch, o_ack}, {4'hf, 3'b100});
		i_nrst = 1'b1;
		repeat (4) @(negedge i_clk);
	endtask : do_reset

	// One core request held until acknowledged, bus pins observed meanwhile
	task automatic bus_op(input logic we, input logic [21:0] a, input logic [15:0] wd);
		@(negedge i_clk);
		cyc = 0;
		cs_seen = 4'hf;
		{even_seen, odd_seen, oe1_seen} = 3'b000;
		{i_req, i_we, i_addr, i_wdata} = {1'b1, we, a, wd};
		for (int n = 1; n < 40 && cyc == 0; n++) begin
			@(negedge i_clk);
			if (o_addr_latch === 1'b1) {ale_addr, ale_data} = {o_addr, o_data};
			cs_seen &= o_chip_select_n;
			even_seen |= ~o_write_strobe_even_n;
			odd_seen |= ~o_write_strobe_odd_n;
			oe1_seen |= o_data_oe[1];
			if (o_ack === 1'b1) cyc = n;
		end
		i_req = 1'b0;
		cmp(cyc != 0, 1'b1);
	endtask : bus_op

	task automatic dec(input logic [21:0] a, input region_t r, input logic v);
		@(negedge i_clk);
		i_addr = a;
		#10;
		cmp(o_region, r);
		cmp(o_vector, v);
	endtask : dec

	task automatic s_single_chip();
		do_reset(1'b0, 1'b0, 1'b0);
		cmp(o_single_chip, 1'b1);
		dec(22'h040000, RGN_NONE, 1'b0);
		bus_op(1'b0, 22'h000500, 16'h0000);
		cmp(cs_seen, 4'hf);
	endtask : s_single_chip

	task automatic s_decode();
		dec(22'h000000, RGN_SPR, 1'b0);
		dec(22'h0003ff, RGN_SPR, 1'b0);
		dec(22'h00d000, RGN_SPR, 1'b0);
		dec(22'h00d7ff, RGN_SPR, 1'b0);
		dec(22'h000400, RGN_RAM, 1'b0);
		dec(22'h002bff, RGN_RAM, 1'b0);
		dec(22'h00e000, RGN_DFLASH, 1'b0);
		dec(22'h00ffff, RGN_DFLASH, 1'b0);
		dec(22'h010000, RGN_PROM2, 1'b0);
		dec(22'h013fff, RGN_PROM2, 1'b0);
		dec(22'h040000, RGN_EXT, 1'b0);
		dec(22'h0bffff, RGN_EXT, 1'b0);
		dec(22'h0f0000, RGN_PROM1, 1'b0);
		dec(22'h0fffdb, RGN_PROM1, 1'b0);
		@(negedge i_clk) i_addr = 22'h0fffdc;
		#10 cmp(o_vector, 1'b1);
		i_area_expand = 1'b1;
		dec(22'h100000, RGN_EXT, 1'b0);
		i_area_expand = 1'b0;
	endtask : s_decode

	task automatic s_sep16();
		bus_op(1'b0, 22'h050006, 16'h0000);
		cmp(cyc, 4);
		cmp(ale_addr, 20'h50006);
		cmp(cs_seen, 4'hd);
		cmp(o_rdata, 16'h6393);
		bus_op(1'b1, 22'h040008, 16'h1234);
		cmp({even_seen, written}, {1'b1, 16'h1234});
		bus_op(1'b1, 22'h040009, 16'h5600);
		cmp({even_seen, odd_seen}, 2'b01);
		i_combined_strobes = 1'b1;
		bus_op(1'b1, 22'h04000b, 16'h7700);
		cmp({even_seen, odd_seen, written}, {2'b11, 16'h7700});
		i_combined_strobes = 1'b0;
		slow = 4'h3;
		bus_op(1'b0, 22'h04000a, 16'h0000);
		slow = 4'h0;
		cmp(cyc, 7);
		cmp(o_rdata, 16'h6595);
		i_multiplexed = 1'b1;
		bus_op(1'b0, 22'h040186, 16'h0000);
		cmp(ale_data[7:0], 8'hc3);
		i_multiplexed = 1'b0;
	endtask : s_sep16

	task automatic s_hold();
		int n;
		n = 0;
		@(negedge i_clk);
		{i_hold_enter, i_hold_request_n} = 2'b10;
		while (o_hold_acknowledge_n !== 1'b0 && n < 12) @(negedge i_clk) n++;
		cmp(o_hold_acknowledge_n, 1'b0);
		i_hold_request_n = 1'b1;
		repeat (8) @(negedge i_clk);
		cmp(o_hold_acknowledge_n, 1'b1);
		i_hold_enter = 1'b0;
	endtask : s_hold

	task automatic s_bus8();
		do_reset(1'b1, 1'b1, 1'b0);
		bus_op(1'b1, 22'h060003, 16'hab00);
		cmp({even_seen, odd_seen, oe1_seen}, 3'b110);
		cmp(written[7:0], 8'hab);
		bus_op(1'b0, 22'h060005, 16'h0000);
		cmp(o_rdata, 16'h0092);
		bus_op(1'b0, 22'h070004, 16'h0000);
		cmp({odd_seen, o_rdata[7:0], cs_seen}, {1'b0, 8'h92, 4'h7});
		i_multiplexed = 1'b1;
		bus_op(1'b0, 22'h0400c5, 16'h0000);
		cmp(ale_data[7:0], 8'hc5);
	endtask : s_bus8

	// Main sequence
	initial begin
		{errors, checked, ticks} = 0;
		slow = 4'h0;
		{i_nrst, i_bus_width_8, i_processor_mode_strap, i_multiplexed, i_combined_strobes} = 5'b00000;
		{i_area_expand, i_hold_enter, i_req, i_we, i_hold_request_n} = 5'b00001;
		i_addr = 22'h000000;
		i_wdata = 16'h0000;
		s_single_chip();
		do_reset(1'b1, 1'b0, 1'b0);
		cmp(o_single_chip, 1'b0);
		s_decode();
		s_sep16();
		s_hold();
		s_bus8();
		give_verdict();
	end
endmodule : tb
`default_nettype wire
